// ---- src/mprs_sequencer.sv ----
// power-up, suspend and reset sequencer facing the carrier board
`timescale 1ns/1ps
module mprs_sequencer
   import mprs_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYCLES,
   parameter int GPIOS = GPIO_COUNT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic input_power_fault_n,
   input wire logic input_power_fault_driven,
   input wire logic reset_request_n,
   input wire logic pwr_key_n,
   input wire logic recovery_request_n,
   input wire logic auto_power_on,
   input wire logic [2:0] boot_source_strap,
   input wire logic software_output_pin,
   input wire logic software_output_pin_en,
   input wire logic gpio_init_done,
   input wire logic [GPIOS-1:0] gpio_oe_request,
   output logic internal_power_enable,
   output logic core_power_enable,
   output logic carrier_supply_enable,
   output logic carrier_standby_n,
   output logic carrier_reset_n,
   output logic boot_start,
   output logic serial_download_mode,
   output logic boot_from_nor,
   output logic [GPIOS-1:0] gpio_oe,
   output logic [GPIOS-1:0] gpio_pull_down
);
   localparam int CW = $clog2(SETTLE + 1);

   logic [SYNC_WIDTH-1:0] raw_in;
   logic [SYNC_WIDTH-1:0] synced;
   logic fault_ok;
   logic reset_ok;
   logic key_level;
   logic recov_ok;
   logic key_prev;
   logic key_event;
   logic strap_taken;
   logic auto_mode;
   logic first_on_done;
   mprs_state_t state;
   mprs_state_t next_state;
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic next_first_on_done;
   logic next_internal_power_enable;
   logic next_core_power_enable;
   logic next_carrier_supply_enable;
   logic next_carrier_standby_n;
   logic next_carrier_reset_n;
   logic next_boot_start;
   logic next_serial_download_mode;
   logic next_boot_from_nor;
   logic [GPIOS-1:0] next_gpio_oe;
   logic [GPIOS-1:0] next_gpio_pull_down;

   // an undriven fault line floats to its inactive high level
   assign raw_in[SYNC_FAULT] = input_power_fault_driven ? input_power_fault_n : 1'b1;
   assign raw_in[SYNC_RESET] = reset_request_n;
   assign raw_in[SYNC_KEY] = pwr_key_n;
   assign raw_in[SYNC_RECOV] = recovery_request_n;

   mprs_sync #(.WIDTH(SYNC_WIDTH), .RESET_VALUE(SYNC_RESET_VALUE)) u_sync (
      .clk(clk),
      .rst(rst),
      .d(raw_in),
      .q(synced)
   );

   // decoded synchronised levels; a low fault line means power not good
   assign fault_ok = synced[SYNC_FAULT];
   assign reset_ok = synced[SYNC_RESET];
   assign key_level = synced[SYNC_KEY];
   assign recov_ok = synced[SYNC_RECOV];
   assign key_event = key_prev && !key_level;

   // strap caught on the first edge after reset release, never under reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         key_prev <= 1'b1;
         strap_taken <= 1'b0;
         auto_mode <= 1'b0;
      end else begin
         key_prev <= key_level;
         strap_taken <= 1'b1;
         if (!strap_taken) begin
            auto_mode <= auto_power_on;
         end
      end
   end

   // sequencer next state; fault beats reset request beats button
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_first_on_done = first_on_done;
      unique case (state)
         ST_OFF: begin
            // auto mode starts once only, later starts need the button
            if (fault_ok && strap_taken && ((auto_mode && !first_on_done) || key_event)) begin
               next_state = ST_POWER_UP;
               next_cnt = '0;
               next_first_on_done = 1'b1;
            end
         end
         ST_POWER_UP: begin
            // give carrier supplies time to come up under reset
            if (cnt == CW'(SETTLE - 1)) begin
               next_state = ST_RESET_HOLD;
            end else begin
               next_cnt = cnt + CW'(1);
            end
         end
         ST_RESET_HOLD: begin
            if (reset_ok) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!reset_ok) begin
               next_state = ST_RESET_HOLD;
            end else if (key_event) begin
               next_state = ST_SUSPEND;
            end
         end
         ST_SUSPEND: begin
            if (key_event) begin
               next_state = ST_POWER_UP;
               next_cnt = '0;
            end
         end
      endcase
      if (!fault_ok) begin
         next_state = ST_OFF;
         next_cnt = '0;
      end
   end

   // outputs follow the next state so every pin is a flip-flop
   always_comb begin
      next_internal_power_enable = fault_ok;
      next_core_power_enable = (next_state == ST_POWER_UP) || (next_state == ST_RESET_HOLD) ||
                               (next_state == ST_RUN);
      next_carrier_supply_enable = (next_state != ST_OFF);
      next_carrier_standby_n = (next_state != ST_OFF) && (next_state != ST_SUSPEND);
      next_carrier_reset_n = 1'b0;
      if (next_state == ST_RUN) begin
         // software may pull reset low again once booted
         next_carrier_reset_n = software_output_pin_en ? software_output_pin : 1'b1;
      end
      next_boot_start = (state == ST_RESET_HOLD) && (next_state == ST_RUN);
      next_serial_download_mode = serial_download_mode;
      if (next_boot_start) begin
         next_serial_download_mode = !recov_ok;
      end
      // boot from NOR unless serial download mode was taken; the strap pins carry no meaning here
      next_boot_from_nor = !next_serial_download_mode;
   end

   // control pins stay inputs with pull-downs until firmware takes them
   for (genvar i = 0; i < GPIOS; i++) begin : g_pin
      always_comb begin
         next_gpio_oe[i] = gpio_init_done && gpio_oe_request[i];
         next_gpio_pull_down[i] = !gpio_init_done;
      end
   end

   // register stage for state and every output
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ST_OFF;
         cnt <= '0;
         first_on_done <= 1'b0;
         internal_power_enable <= 1'b0;
         core_power_enable <= 1'b0;
         carrier_supply_enable <= 1'b0;
         carrier_standby_n <= 1'b0;
         carrier_reset_n <= 1'b0;
         boot_start <= 1'b0;
         serial_download_mode <= 1'b0;
         boot_from_nor <= 1'b1;
         gpio_oe <= '0;
         gpio_pull_down <= '1;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         first_on_done <= next_first_on_done;
         internal_power_enable <= next_internal_power_enable;
         core_power_enable <= next_core_power_enable;
         carrier_supply_enable <= next_carrier_supply_enable;
         carrier_standby_n <= next_carrier_standby_n;
         carrier_reset_n <= next_carrier_reset_n;
         boot_start <= next_boot_start;
         serial_download_mode <= next_serial_download_mode;
         boot_from_nor <= next_boot_from_nor;
         gpio_oe <= next_gpio_oe;
         gpio_pull_down <= next_gpio_pull_down;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_fault_power_off: assert property (!fault_ok |=> !internal_power_enable && !carrier_supply_enable)
      else $error("power stayed on with fault asserted");
   a_powerup_outputs: assert property (state == ST_POWER_UP |-> carrier_supply_enable && carrier_standby_n)
      else $error("carrier power not enabled during power-up");
   a_powerup_reset_low: assert property (state == ST_POWER_UP ##1 state == ST_POWER_UP |-> !carrier_reset_n)
      else $error("carrier reset released during power-up");
   a_settle_length: assert property ($rose(state == ST_POWER_UP) ##1 fault_ok[*8] |-> state == ST_POWER_UP)
      else $error("power-up settle ended early");
   a_boot_needs_release: assert property (boot_start |-> $past(reset_ok) && state == ST_RUN)
      else $error("boot started with reset request low");
   a_request_resets: assert property (state == ST_RUN && !reset_ok && fault_ok
                                      |=> !carrier_reset_n && !boot_start && state == ST_RESET_HOLD)
      else $error("reset request did not reset carrier");
   a_sw_reset_drive: assert property (state == ST_RUN && reset_ok && fault_ok && !key_event && software_output_pin_en
                                      |=> carrier_reset_n == $past(software_output_pin))
      else $error("software reset drive ignored");
   a_key_suspend: assert property (state == ST_RUN && key_event && reset_ok && fault_ok
                                   |=> !carrier_standby_n && !core_power_enable && carrier_supply_enable)
      else $error("button did not enter suspend");
   a_key_wake: assert property (state == ST_SUSPEND && key_event && fault_ok |=> state == ST_POWER_UP)
      else $error("button did not wake from suspend");
   a_recovery_mode: assert property (boot_start |-> serial_download_mode == !$past(recov_ok))
      else $error("download mode not taken at boot");
   a_pins_inputs: assert property (!gpio_init_done |=> gpio_oe == '0 && gpio_pull_down == '1)
      else $error("control pins driven before init");

   c_boot: cover property (boot_start);
   c_suspend: cover property (state == ST_RUN ##1 state == ST_SUSPEND);
   c_wake: cover property (state == ST_SUSPEND ##1 state == ST_POWER_UP);
   c_recovery: cover property (boot_start && serial_download_mode);
endmodule : mprs_sequencer

// ---- src/mprs_pkg.sv ----
// constants and state type of the module power and reset sequencer
// What this block does
// - A low level on the input-power-fault input means the module input voltage is not ready or out of range.
// - Internal power circuits are enabled only while the input-power-fault line is not driven low.
// - An undriven input-power-fault line reads as high, as through a pull-up.
// - Power-up starts either at the first power-on or at a power-button event, as configured.
// - Once power-up starts, the carrier supply enable is asserted and the carrier standby output is driven high.
// - The carrier supply enable is active high and switches on the carrier supplies.
// - The carrier reset output is held low during power-up and released to start booting.
// - The carrier reset is released and booting starts only while the reset request input is high.
// - A low reset request forces a reset or reboot, and holding it low at power-on postpones booting.
// - Software can also drive the carrier reset output through a general-purpose output.
// - The active-low carrier standby output signals suspend, in which core power is removed.
// - A power-button event wakes the system from, or sends it into, the always-on low-power mode.
// - A low recovery request at boot selects serial download over the first USB port.
// - Boot-source straps are ignored and the first-stage loader comes from the onboard NOR flash unless serial download mode was taken.
// - Control pins come up as inputs with pull-downs until firmware initialises them.
package mprs_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int SETTLE_TIME_NS = 10000;
   localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GPIO_COUNT = 19;
   localparam int SYNC_WIDTH = 4;
   localparam int SYNC_FAULT = 0;
   localparam int SYNC_RESET = 1;
   localparam int SYNC_KEY = 2;
   localparam int SYNC_RECOV = 3;
   // fault bit resets to not-good: nothing may power up before the real line has crossed the synchroniser
   localparam logic [3:0] SYNC_RESET_VALUE = 4'hE;
   typedef enum logic [2:0] {ST_OFF, ST_POWER_UP, ST_RESET_HOLD, ST_RUN, ST_SUSPEND} mprs_state_t;
endpackage : mprs_pkg

// ---- src/mprs_sync.sv ----
// two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module mprs_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage1;

   // first stage feeds only the second; reset to the safe level chosen by the parent
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1 <= RESET_VALUE;
         q <= RESET_VALUE;
      end else begin
         stage1 <= d;
         q <= stage1;
      end
   end
endmodule : mprs_sync

// ---- verification/mprs_carrier_model.sv ----
// carrier board model: input-power fault line and reset request
`timescale 1ns/1ps
module mprs_carrier_model #(
   parameter int RISE = 5
) (
   input wire logic clk,
   input wire logic power_on,
   input wire logic drive_fault,
   input wire logic hold_reset,
   output logic fault_n,
   output logic fault_driven,
   output logic reset_request_n
);
   int rise_cnt = 0;
   // supply ramp: input counts as stable only after RISE cycles of power
   always @(posedge clk) begin
      if (!power_on) rise_cnt <= 0;
      else if (rise_cnt < RISE) rise_cnt <= rise_cnt + 1;
   end
   // a released line shows low on purpose, so only the device pull-up can make it read high
   assign fault_n = drive_fault && power_on && rise_cnt >= RISE;
   assign fault_driven = drive_fault;
   assign reset_request_n = !hold_reset;
endmodule : mprs_carrier_model

// ---- verification/tb_module_power_reset_sequencer.sv ----
// self-checking bench for the power and reset sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
`define WAIT(c) begin k = 0; while (!(c) && k < 80) begin step(1); k++; end if (k == 80) n_errors++; end
module tb_module_power_reset_sequencer;
   import mprs_pkg::*;
   logic clk = 0, rst = 1, power_on = 1, drive_fault = 1, hold_reset = 1;
   logic fault_n, fault_driven, reset_request_n;
   logic pwr_key_n = 1, recovery_request_n = 0, auto_power_on = 1, sw_pin = 1, sw_en = 0, gpio_init_done = 0;
   logic [2:0] strap = 3'h5;
   logic [18:0] oe_req = 19'h5A5A5, gpio_oe, gpio_pull_down;
   logic internal_power_enable, core_power_enable, carrier_supply_enable, carrier_standby_n, carrier_reset_n;
   logic boot_start, serial_download_mode, boot_from_nor;
   int n_errors = 0, n_compared = 0, k;
   mprs_carrier_model mprs_carrier_model_inst (.clk(clk), .power_on(power_on), .drive_fault(drive_fault),
      .hold_reset(hold_reset), .fault_n(fault_n), .fault_driven(fault_driven), .reset_request_n(reset_request_n));
   mprs_sequencer #(.SETTLE(10)) mprs_sequencer_inst (.clk(clk), .rst(rst), .input_power_fault_n(fault_n),
      .input_power_fault_driven(fault_driven), .reset_request_n(reset_request_n), .pwr_key_n(pwr_key_n),
      .recovery_request_n(recovery_request_n), .auto_power_on(auto_power_on), .boot_source_strap(strap),
      .software_output_pin(sw_pin), .software_output_pin_en(sw_en), .gpio_init_done(gpio_init_done),
      .gpio_oe_request(oe_req), .internal_power_enable(internal_power_enable),
      .core_power_enable(core_power_enable), .carrier_supply_enable(carrier_supply_enable),
      .carrier_standby_n(carrier_standby_n), .carrier_reset_n(carrier_reset_n), .boot_start(boot_start),
      .serial_download_mode(serial_download_mode), .boot_from_nor(boot_from_nor), .gpio_oe(gpio_oe),
      .gpio_pull_down(gpio_pull_down));
   // 10 MHz clock
   always #50 clk = ~clk;
   // inputs always move 10 ns after the rising edge, so no race with the design's flops
   task step(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask : step
   // first boot with reset request held low and recovery requested
   task power_up_boot;
      // outputs only take their reset values at the first clock edge under reset
      step(2);
      `CHK(boot_from_nor, 1'b1)
      `CHK(gpio_pull_down, 19'h7FFFF)
      rst = 0;
      `WAIT(carrier_supply_enable === 1'b1)
      `CHK(internal_power_enable, 1'b1)
      `CHK(carrier_standby_n, 1'b1)
      `CHK(carrier_reset_n, 1'b0)
      step(30);
      `CHK(carrier_reset_n, 1'b0)
      hold_reset = 0;
      `WAIT(boot_start === 1'b1)
      `CHK(carrier_reset_n, 1'b1)
      step(1);
      `CHK(boot_start, 1'b0)
      `CHK(serial_download_mode, 1'b1)
      `CHK(boot_from_nor, 1'b0)
   endtask : power_up_boot
   // software reset drive, then a reboot request without recovery
   task reboot;
      recovery_request_n = 1;
      sw_en = 1;
      sw_pin = 0;
      step(2);
      `CHK(carrier_reset_n, 1'b0)
      sw_pin = 1;
      step(2);
      `CHK(carrier_reset_n, 1'b1)
      sw_en = 0;
      hold_reset = 1;
      `WAIT(carrier_reset_n === 1'b0)
      step(20);
      `CHK(carrier_reset_n, 1'b0)
      hold_reset = 0;
      `WAIT(boot_start === 1'b1)
      step(1);
      `CHK(boot_from_nor, 1'b1)
   endtask : reboot
   // button edge into suspend and back out
   task suspend_wake;
      pwr_key_n = 0;
      `WAIT(carrier_standby_n === 1'b0)
      `CHK(core_power_enable, 1'b0)
      pwr_key_n = 1;
      step(6);
      `CHK(carrier_standby_n, 1'b0)
      pwr_key_n = 0;
      `WAIT(carrier_standby_n === 1'b1)
      `CHK(carrier_reset_n, 1'b0)
      pwr_key_n = 1;
      `WAIT(boot_start === 1'b1)
      `CHK(core_power_enable, 1'b1)
   endtask : suspend_wake
   // fault shutdown, undriven line, restart only by button
   task fault_restart;
      power_on = 0;
      `WAIT(carrier_supply_enable === 1'b0)
      `CHK(internal_power_enable, 1'b0)
      `CHK(carrier_reset_n, 1'b0)
      drive_fault = 0;
      `WAIT(internal_power_enable === 1'b1)
      step(20);
      `CHK(carrier_supply_enable, 1'b0)
      pwr_key_n = 0;
      `WAIT(carrier_supply_enable === 1'b1)
      `CHK(internal_power_enable, 1'b1)
      pwr_key_n = 1;
   endtask : fault_restart
   // pins stay inputs with pull-downs until firmware is done
   task gpio_release;
      `CHK(gpio_oe, 19'h00000)
      gpio_init_done = 1;
      `WAIT(gpio_pull_down === 19'h00000)
      `CHK(gpio_oe, oe_req)
   endtask : gpio_release
   // mid-run reset with button start configured and straps moved
   task button_start;
      auto_power_on = 0;
      strap = 3'h2;
      rst = 1;
      step(2);
      `CHK(carrier_supply_enable, 1'b0)
      `CHK(gpio_pull_down, 19'h7FFFF)
      rst = 0;
      step(20);
      `CHK(carrier_supply_enable, 1'b0)
      `CHK(internal_power_enable, 1'b1)
      `CHK(boot_from_nor, 1'b1)
      pwr_key_n = 0;
      `WAIT(carrier_supply_enable === 1'b1)
      `CHK(carrier_standby_n, 1'b1)
      `CHK(carrier_reset_n, 1'b0)
      pwr_key_n = 1;
   endtask : button_start
   task close_out;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   // main sequence
   initial begin
      #10;
      power_up_boot();
      reboot();
      suspend_wake();
      fault_restart();
      gpio_release();
      button_start();
      close_out();
   end
   // watchdog sized well beyond the few hundred cycles the tests need
   initial begin
      #(3000 * 100);
      n_errors++;
      close_out();
   end
endmodule : tb_module_power_reset_sequencer
